// ### logic/rail_src_pkg.sv
// package: register map, field layout and sleep behaviour codes for the rail select block
`default_nettype none
package rail_src_pkg;
  localparam int RAIL_COUNT = 8;
  localparam int VOLT_W = 8;
  localparam logic [7:0] SRC_SEL_ADDR = 8'h2B;
  localparam logic [7:0] SRC_SEL_RESET_DEFAULT = 8'h00;
  localparam int CONV_LSB = 0;
  localparam int REG_LSB = 4;
  localparam logic SEL_OPERATING = 1'b0;
  localparam logic SEL_SCALING = 1'b1;

  // sleep behaviour of one rail
  typedef enum logic [1:0] {
    SLEEP_ECO,
    SLEEP_ACTIVE,
    SLEEP_OFF
  } sleep_mode_t;

  // serial control interface register access, already decoded by the frame logic
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;
endpackage
`default_nettype wire

// ### logic/rail_voltage_source_select.sv
// design: rail voltage source select register and sleep behaviour decode
`timescale 1ns/1ps
`default_nettype none

module rail_voltage_source_select
  import rail_src_pkg::*;
#(
  parameter logic [7:0] OTP_DEFAULT = SRC_SEL_RESET_DEFAULT
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register access from the serial control interface
  input wire reg_access_t acc_i,
  output logic [7:0] rdata_o,
  // per rail configuration
  input wire logic [RAIL_COUNT-1:0] keep_on_i,
  input wire logic [RAIL_COUNT-1:0] set_off_i,
  input wire logic [RAIL_COUNT-1:0] rail_en_i,
  input wire logic [RAIL_COUNT*VOLT_W-1:0] op_volt_i,
  input wire logic [RAIL_COUNT*VOLT_W-1:0] avs_volt_i,
  // per rail results
  output logic [RAIL_COUNT-1:0] source_sel_o,
  output logic [RAIL_COUNT*VOLT_W-1:0] volt_set_o,
  output logic [RAIL_COUNT*2-1:0] sleep_mode_o,
  output logic [RAIL_COUNT-1:0] rail_en_o
);

  logic [7:0] src_sel_reg;

  // decode of one rail's sleep behaviour, keep-on dominating set-off
  function automatic sleep_mode_t sleep_decode(input logic keep_on, input logic set_off);
    sleep_mode_t m;
    m = SLEEP_ECO;
    if (keep_on) begin
      m = SLEEP_ACTIVE;
    end else if (set_off) begin
      m = SLEEP_OFF;
    end else begin
      m = SLEEP_ECO;
    end
    return m;
  endfunction

  // select register; default is the one-time-programmed value given as parameter
  // variants differ only in this default, so it stays a parameter and not a constant
  // a write to any other address is dropped here, the neighbouring map lives elsewhere
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      src_sel_reg <= OTP_DEFAULT;
    end else if (acc_i.wr && acc_i.addr == SRC_SEL_ADDR) begin
      src_sel_reg <= acc_i.wdata;
    end
  end

  // read data, unmapped addresses read zero
  // a read in the same cycle as a write returns the old value, the write lands after
  // rdata_o holds between reads so the frame logic may fetch it late
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (acc_i.rd) begin
      rdata_o <= (acc_i.addr == SRC_SEL_ADDR) ? src_sel_reg : 8'h00;
    end
  end

  // voltage source mux; sleep mode does not enter it, so the choice holds in every mode
  // the chosen setting trails a select write by two edges; the analogue side sees
  // the new target only then, which is the price of registering every output
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      volt_set_o <= '0;
      source_sel_o <= '0;
    end else begin
      source_sel_o <= src_sel_reg;
      for (int i = 0; i < RAIL_COUNT; i++) begin
        if (src_sel_reg[i] == SEL_SCALING) begin
          volt_set_o[i*VOLT_W +: VOLT_W] <= avs_volt_i[i*VOLT_W +: VOLT_W];
        end else begin
          volt_set_o[i*VOLT_W +: VOLT_W] <= op_volt_i[i*VOLT_W +: VOLT_W];
        end
      end
    end
  end

  // sleep decode per rail
  // keep-on dominates set-off; the fourth code is never produced
  // the decode is only a request, the sleep entry itself is sequenced elsewhere
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sleep_mode_o <= '0;
    end else begin
      for (int i = 0; i < RAIL_COUNT; i++) begin
        sleep_mode_o[i*2 +: 2] <= sleep_decode(keep_on_i[i], set_off_i[i]);
      end
    end
  end

  // enable passes through untouched by select writes
  // registering it keeps enable and voltage aligned to the same edge downstream
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rail_en_o <= '0;
    end else begin
      rail_en_o <= rail_en_i;
    end
  end

  // checks
  mux_scaling_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $past(src_sel_reg[0]) && !$past(rst_i) |-> volt_set_o[7:0] == $past(avs_volt_i[7:0]))
    else $error("rail 0 not on scaling voltage");
  mux_operating_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(src_sel_reg[7]) && !$past(rst_i) |-> volt_set_o[63:56] == $past(op_volt_i[63:56]))
    else $error("rail 7 not on operating voltage");
  sel_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    acc_i.wr && acc_i.addr == SRC_SEL_ADDR |=> src_sel_reg == $past(acc_i.wdata))
    else $error("select write lost");
  sel_reset_a: assert property (@(posedge core_clk_i) rst_i |=> src_sel_reg == OTP_DEFAULT)
    else $error("select not at default after reset");
  sleep_eco_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !keep_on_i[4] && !set_off_i[4] |=> sleep_mode_o[9:8] == SLEEP_ECO)
    else $error("rail 4 not eco");
  sleep_active_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    keep_on_i[5] |=> sleep_mode_o[11:10] == SLEEP_ACTIVE)
    else $error("rail 5 not active");
  sleep_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !keep_on_i[6] && set_off_i[6] |=> sleep_mode_o[13:12] == SLEEP_OFF)
    else $error("rail 6 not off");
  enable_kept_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    acc_i.wr |=> rail_en_o == $past(rail_en_i))
    else $error("enable disturbed by write");
  src_in_sleep_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ##1 !$past(rst_i) |-> source_sel_o == $past(src_sel_reg))
    else $error("source select not presented");

  // register access path
  read_select_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    acc_i.rd && acc_i.addr == SRC_SEL_ADDR |=> rdata_o == $past(src_sel_reg))
    else $error("select read wrong");
  read_unmapped_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    acc_i.rd && acc_i.addr != SRC_SEL_ADDR |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  read_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !acc_i.rd |=> $stable(rdata_o))
    else $error("read data moved without read");
  sel_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(acc_i.wr && acc_i.addr == SRC_SEL_ADDR) |=> $stable(src_sel_reg))
    else $error("select changed without write");
  enable_on_change_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    src_sel_reg != $past(src_sel_reg) && !$past(rst_i) |-> rail_en_o == $past(rail_en_i))
    else $error("enable disturbed by select change");

  // source mux on converter and regulator rails
  mux_scale_conv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $past(src_sel_reg[3]) && !$past(rst_i) |-> volt_set_o[31:24] == $past(avs_volt_i[31:24]))
    else $error("rail 3 not on scaling voltage");
  mux_scale_reg_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $past(src_sel_reg[4]) && !$past(rst_i) |-> volt_set_o[39:32] == $past(avs_volt_i[39:32]))
    else $error("rail 4 not on scaling voltage");
  mux_scale_last_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $past(src_sel_reg[7]) && !$past(rst_i) |-> volt_set_o[63:56] == $past(avs_volt_i[63:56]))
    else $error("rail 7 not on scaling voltage");
  mux_oper_conv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(src_sel_reg[0]) && !$past(rst_i) |-> volt_set_o[7:0] == $past(op_volt_i[7:0]))
    else $error("rail 0 not on operating voltage");
  mux_oper_reg_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(src_sel_reg[4]) && !$past(rst_i) |-> volt_set_o[39:32] == $past(op_volt_i[39:32]))
    else $error("rail 4 not on operating voltage");
  mux_oper_mid_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(src_sel_reg[3]) && !$past(rst_i) |-> volt_set_o[31:24] == $past(op_volt_i[31:24]))
    else $error("rail 3 not on operating voltage");

  // sleep decode on further rails
  sleep_eco_conv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !keep_on_i[0] && !set_off_i[0] |=> sleep_mode_o[1:0] == SLEEP_ECO)
    else $error("rail 0 not eco");
  sleep_off_conv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !keep_on_i[1] && set_off_i[1] |=> sleep_mode_o[3:2] == SLEEP_OFF)
    else $error("rail 1 not off");
  sleep_keep_wins_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    keep_on_i[3] && set_off_i[3] |=> sleep_mode_o[7:6] == SLEEP_ACTIVE)
    else $error("rail 3 set-off overrode keep-on");
  sleep_off_last_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !keep_on_i[7] && set_off_i[7] |=> sleep_mode_o[15:14] == SLEEP_OFF)
    else $error("rail 7 not off");
  sleep_active_last_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    keep_on_i[7] |=> sleep_mode_o[15:14] == SLEEP_ACTIVE)
    else $error("rail 7 not active");
  sleep_eco_mid_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !keep_on_i[2] && !set_off_i[2] |=> sleep_mode_o[5:4] == SLEEP_ECO)
    else $error("rail 2 not eco");

  sel_write_c: cover property (@(posedge core_clk_i) acc_i.wr && acc_i.addr == SRC_SEL_ADDR);
  sel_read_c: cover property (@(posedge core_clk_i) acc_i.rd && acc_i.addr == SRC_SEL_ADDR);
  off_scaling_c: cover property (@(posedge core_clk_i)
    sleep_mode_o[1:0] == SLEEP_OFF && src_sel_reg[0]);
  unmapped_wr_c: cover property (@(posedge core_clk_i)
    acc_i.wr && acc_i.addr != SRC_SEL_ADDR);
  keep_over_off_c: cover property (@(posedge core_clk_i)
    keep_on_i[3] && set_off_i[3] && src_sel_reg[3]);

endmodule

`default_nettype wire

// ### tb/host_model.sv
// host model: issues register accesses on the decoded serial interface
`timescale 1ns/1ps
`default_nettype none
module host_model
  import rail_src_pkg::*;
(
  input wire logic core_clk_i,
  output var reg_access_t acc_o
);
  initial acc_o = '0;
  // one-cycle strobe; address and data go stale (inverted) once released
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i) acc_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk_i) acc_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// testbench: random and corner checks of the rail select block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rail_src_pkg::*;
  logic core_clk_i, rst_i;
  reg_access_t acc;
  logic [7:0] rdata, sel, keep_on, set_off, rail_en, en_q, exp_sel, addr, wdata;
  logic [63:0] op_volt, avs_volt, volt;
  logic [15:0] mode, lf;
  int err_count, comparisons;
  host_model i_host (.core_clk_i(core_clk_i), .acc_o(acc));
  rail_voltage_source_select i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .acc_i(acc),
    .rdata_o(rdata), .keep_on_i(keep_on), .set_off_i(set_off), .rail_en_i(rail_en),
    .op_volt_i(op_volt), .avs_volt_i(avs_volt), .source_sel_o(sel), .volt_set_o(volt),
    .sleep_mode_o(mode), .rail_en_o(en_q));
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // per rail: voltage of the chosen register, sleep code from keep-on over set-off
  function automatic logic [63:0] exp_volt(input logic [7:0] s);
    for (int i = 0; i < 8; i++) exp_volt[8*i+:8] = s[i] ? avs_volt[8*i+:8] : op_volt[8*i+:8];
  endfunction
  function automatic logic [15:0] exp_mode();
    for (int i = 0; i < 8; i++)
      exp_mode[2*i+:2] = keep_on[i] ? SLEEP_ACTIVE : (set_off[i] ? SLEEP_OFF : SLEEP_ECO);
  endfunction
  task automatic check(input string n, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // free-running 25 MHz clock
  initial begin
    core_clk_i = 0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // all-scaling and all-operating writes first, then random ones, every fifth access (from the third) to an unmapped address
  initial begin
    rst_i = 1;
    lf = 16'h000F;
    {keep_on, set_off, rail_en, op_volt, avs_volt} = '0;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 0;
    exp_sel = SRC_SEL_RESET_DEFAULT;
    for (int n = 0; n < 40; n++) begin
      @(posedge core_clk_i);
      lf = nxt(lf);
      {keep_on, set_off} <= lf;
      rail_en <= lf[15:8] ^ 8'hA5;
      op_volt <= {4{lf}};
      avs_volt <= {4{~lf ^ 16'h3C96}};
      wdata = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : lf[11:4];
      addr = (n % 5 == 2) ? 8'h2C : SRC_SEL_ADDR;
      i_host.access(1'b1, addr, wdata);
      if (addr === SRC_SEL_ADDR) exp_sel = wdata;
      repeat (3) @(posedge core_clk_i);
      i_host.access(1'b0, addr, 8'h00);
      @(posedge core_clk_i);
      #1;
      check("rdata_o", (addr === SRC_SEL_ADDR) ? 64'(exp_sel) : 64'h0, 64'(rdata));
      check("source_sel_o", 64'(exp_sel), 64'(sel));
      check("volt_set_o", exp_volt(exp_sel), volt);
      check("sleep_mode_o", 64'(exp_mode()), 64'(mode));
      check("rail_en_o", 64'(rail_en), 64'(en_q));
    end
    // mid-run reset must bring back the programmed default
    @(posedge core_clk_i) rst_i <= 1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 0;
    @(posedge core_clk_i);
    #1;
    check("reset sel", 64'(SRC_SEL_RESET_DEFAULT), 64'(sel));
    final_report();
  end
endmodule
`default_nettype wire
